// ==== common/fpq_regs.vh ====
// constants for the flash protection and query host controller
`ifndef FPQ_REGS_VH
`define FPQ_REGS_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FPQ_CLK_NS 10
`define FPQ_T_SETUP_NS 10
`define FPQ_T_WP_NS 35
`define FPQ_T_ACC_NS 90
`define FPQ_T_ELEV_NS 4000
`define FPQ_WP_CYC ((`FPQ_T_WP_NS + `FPQ_CLK_NS - 1) / `FPQ_CLK_NS)
`define FPQ_ACC_CYC ((`FPQ_T_ACC_NS + `FPQ_CLK_NS - 1) / `FPQ_CLK_NS)
`define FPQ_ELEV_CYC ((`FPQ_T_ELEV_NS + `FPQ_CLK_NS - 1) / `FPQ_CLK_NS)
`define FPQ_CNT_W 9

// ----------------------------------------------------------------
// register map (byte offsets)
// ----------------------------------------------------------------
`define FPQ_OFF_CTRL 8'h00
`define FPQ_OFF_ADDR 8'h04
`define FPQ_OFF_WDATA 8'h08
`define FPQ_OFF_RDATA 8'h0C
`define FPQ_OFF_STATUS 8'h10
`define FPQ_OFF_PROT0 8'h14
`define FPQ_OFF_PROT1 8'h18
`define FPQ_IDX_NONE 3'h7

// ctrl fields
`define FPQ_CTRL_OP_HI 2
`define FPQ_CTRL_OP_LO 0
`define FPQ_CTRL_DIE 4
`define FPQ_CTRL_TEMP 8
// status fields
`define FPQ_ST_BUSY 0
`define FPQ_ST_REFUSED 1
`define FPQ_ST_QUERY 2
`define FPQ_ST_SUPPLY_LOW 3
`define FPQ_ST_ELEV 4

// ----------------------------------------------------------------
// operations
// ----------------------------------------------------------------
`define FPQ_OP_NONE 3'h0
`define FPQ_OP_WRITE 3'h1
`define FPQ_OP_READ 3'h2
`define FPQ_OP_QUERY 3'h3
`define FPQ_OP_RESET 3'h4
`define FPQ_OP_PSTAT 3'h5
`define FPQ_OP_PROT 3'h6
`define FPQ_OP_UNPROT 3'h7

// ----------------------------------------------------------------
// flash commands and addresses
// ----------------------------------------------------------------
`define FPQ_CMD_QUERY 16'h0098
`define FPQ_CMD_RESET 16'h00F0
`define FPQ_CMD_UNLOCK1 16'h00AA
`define FPQ_CMD_UNLOCK2 16'h0055
`define FPQ_CMD_IDENT 16'h0090
`define FPQ_CMD_PROTECT 16'h0060
`define FPQ_ADR_QUERY 23'h000055
`define FPQ_ADR_UNLOCK1 23'h000555
`define FPQ_ADR_UNLOCK2 23'h0002AA
`define FPQ_LOW_PSTAT 18'h00002
`define FPQ_LOW_PROT 18'h00000
`define FPQ_LOW_UNPROT 18'h00040
`define FPQ_LOW_ZERO 18'h00000
`define FPQ_GRP_HI 22
`define FPQ_GRP_LO 18
`define FPQ_PROT_YES 8'h01
`define FPQ_ALL_PROT 32'hFFFFFFFF
`define FPQ_NONE_PROT 32'h00000000

`endif

// ==== logic/fpq_cyc.v ====
// single asynchronous flash bus cycle generator (write or read)
`timescale 1ns/1ps
`default_nettype none
`include "fpq_regs.vh"

module fpq_cyc (
	input wire i_clk,
	input wire i_rst,
	input wire i_start,
	input wire i_write,
	input wire [22:0] i_addr,
	input wire [15:0] i_wdata,
	input wire i_die,
	input wire [15:0] i_dq,
	output reg [22:0] o_addr,
	output reg [15:0] o_dq,
	output reg o_dq_oe,
	output reg o_die0_n,
	output reg o_die1_n,
	output reg o_we_n,
	output reg o_oe_n,
	output reg o_done,
	output reg [15:0] o_rdata
);
	localparam ST_IDLE = 4'b0001;
	localparam ST_SETUP = 4'b0010;
	localparam ST_PULSE = 4'b0100;
	localparam ST_HOLD = 4'b1000;
	localparam [31:0] WP_LOAD = `FPQ_WP_CYC - 1;
	localparam [31:0] ACC_LOAD = `FPQ_ACC_CYC - 1;

	reg [3:0] st_q;
	reg wr_q;
	reg [3:0] cnt_q;

	// ----------------------------------------------------------------
	// cycle sequence
	// ----------------------------------------------------------------
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_q <= ST_IDLE;
			wr_q <= 1'b0;
			cnt_q <= 4'h0;
			o_addr <= 23'h000000;
			o_dq <= 16'h0000;
			o_dq_oe <= 1'b0;
			o_die0_n <= 1'b1;
			o_die1_n <= 1'b1;
			o_we_n <= 1'b1;
			o_oe_n <= 1'b1;
			o_done <= 1'b0;
			o_rdata <= 16'h0000;
		end else begin
			o_done <= 1'b0;
			case (st_q)
			ST_IDLE: begin
				if (i_start) begin
					// address and select settle before any strobe falls
					wr_q <= i_write;
					o_addr <= i_addr;
					o_dq <= i_wdata;
					o_dq_oe <= i_write;
					o_die0_n <= i_die;
					o_die1_n <= ~i_die;
					st_q <= ST_SETUP;
				end
			end
			ST_SETUP: begin
				if (wr_q) begin
					o_we_n <= 1'b0;
					cnt_q <= WP_LOAD[3:0];
				end else begin
					o_oe_n <= 1'b0;
					cnt_q <= ACC_LOAD[3:0];
				end
				st_q <= ST_PULSE;
			end
			ST_PULSE: begin
				if (cnt_q == 4'h0) begin
					// we rises first so data is taken while still driven
					o_we_n <= 1'b1;
					o_oe_n <= 1'b1;
					if (!wr_q)
						o_rdata <= i_dq;
					st_q <= ST_HOLD;
				end else begin
					cnt_q <= cnt_q - 4'h1;
				end
			end
			ST_HOLD: begin
				o_die0_n <= 1'b1;
				o_die1_n <= 1'b1;
				o_dq_oe <= 1'b0;
				o_done <= 1'b1;
				st_q <= ST_IDLE;
			end
			default: st_q <= ST_IDLE;
			endcase
		end
	end
endmodule // fpq_cyc
`default_nettype wire

// ==== logic/fpq_apb.v ====
// apb slave front end for the controller's own registers
`timescale 1ns/1ps
`default_nettype none
`include "fpq_regs.vh"

module fpq_apb (
	input wire i_clk,
	input wire i_rst,
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [7:0] i_paddr,
	input wire [31:0] i_ctrl,
	input wire [31:0] i_addr,
	input wire [31:0] i_wdata,
	input wire [31:0] i_rdata,
	input wire [31:0] i_status,
	input wire [31:0] i_prot0,
	input wire [31:0] i_prot1,
	output reg [31:0] o_prdata,
	output wire o_pready,
	output wire o_pslverr,
	output wire o_wr_en,
	output wire [2:0] o_idx
);
	function [2:0] fpq_decode;
		input [7:0] a;
		begin
			case (a)
			`FPQ_OFF_CTRL: fpq_decode = 3'h0;
			`FPQ_OFF_ADDR: fpq_decode = 3'h1;
			`FPQ_OFF_WDATA: fpq_decode = 3'h2;
			`FPQ_OFF_RDATA: fpq_decode = 3'h3;
			`FPQ_OFF_STATUS: fpq_decode = 3'h4;
			`FPQ_OFF_PROT0: fpq_decode = 3'h5;
			`FPQ_OFF_PROT1: fpq_decode = 3'h6;
			default: fpq_decode = `FPQ_IDX_NONE;
			endcase
		end
	endfunction

	wire hit;

	assign o_idx = fpq_decode(i_paddr);
	assign hit = (o_idx != `FPQ_IDX_NONE);
	assign o_pready = 1'b1;
	assign o_pslverr = i_psel & i_penable & ~hit;
	assign o_wr_en = i_psel & i_penable & i_pwrite & hit;

	// read data captured in the setup cycle, valid for the access cycle
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_prdata <= 32'h00000000;
		end else if (i_psel && !i_penable) begin
			case (o_idx)
			3'h0: o_prdata <= i_ctrl;
			3'h1: o_prdata <= i_addr;
			3'h2: o_prdata <= i_wdata;
			3'h3: o_prdata <= i_rdata;
			3'h4: o_prdata <= i_status;
			3'h5: o_prdata <= i_prot0;
			3'h6: o_prdata <= i_prot1;
			default: o_prdata <= 32'h00000000;
			endcase
		end
	end
endmodule // fpq_apb
`default_nettype wire

// ==== logic/fpq_ctrl.v ====
// host controller for sector group protection and query access of a dual-die flash
`timescale 1ns/1ps
`default_nettype none
`include "fpq_regs.vh"

module fpq_ctrl (
	input wire I_MCLK,
	input wire I_SYS_RST,
	input wire I_PSEL,
	input wire I_PENABLE,
	input wire I_PWRITE,
	input wire [7:0] I_PADDR,
	input wire [31:0] I_PWDATA,
	output wire [31:0] O_PRDATA,
	output wire O_PREADY,
	output wire O_PSLVERR,
	input wire I_SUPPLY_LOW,
	input wire [15:0] I_FLASH_DQ,
	output wire [15:0] O_FLASH_DQ,
	output wire O_FLASH_DQ_OE,
	output wire [22:0] O_FLASH_ADDR,
	output wire O_DIE0_SELECT_N,
	output wire O_DIE1_SELECT_N,
	output wire O_WRITE_N,
	output wire O_OUTPUT_EN_N,
	output wire O_ELEV_EN
);
	localparam S_IDLE = 5'b00001;
	localparam S_ELUP = 5'b00010;
	localparam S_CYC = 5'b00100;
	localparam S_WAIT = 5'b01000;
	localparam S_ELDN = 5'b10000;
	localparam [31:0] ELEV_LOAD = `FPQ_ELEV_CYC - 1;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function [4:0] fpq_grp;
		input [22:0] a;
		begin
			fpq_grp = a[`FPQ_GRP_HI:`FPQ_GRP_LO];
		end
	endfunction

	// one flash cycle of an operation: {last, write, address, data}
	function [40:0] fpq_step;
		input [2:0] op;
		input [2:0] step;
		input [22:0] a;
		input [15:0] d;
		reg [4:0] g;
		begin
			g = fpq_grp(a);
			fpq_step = {1'b1, 1'b0, a, 16'h0000};
			case (op)
			`FPQ_OP_WRITE: fpq_step = {1'b1, 1'b1, a, d};
			`FPQ_OP_READ: fpq_step = {1'b1, 1'b0, a, 16'h0000};
			`FPQ_OP_QUERY: fpq_step = {1'b1, 1'b1, `FPQ_ADR_QUERY, `FPQ_CMD_QUERY};
			`FPQ_OP_RESET: fpq_step = {1'b1, 1'b1, a, `FPQ_CMD_RESET};
			`FPQ_OP_PSTAT: begin
				case (step)
				3'h0: fpq_step = {1'b0, 1'b1, `FPQ_ADR_UNLOCK1, `FPQ_CMD_UNLOCK1};
				3'h1: fpq_step = {1'b0, 1'b1, `FPQ_ADR_UNLOCK2, `FPQ_CMD_UNLOCK2};
				3'h2: fpq_step = {1'b0, 1'b1, `FPQ_ADR_UNLOCK1, `FPQ_CMD_IDENT};
				3'h3: fpq_step = {1'b0, 1'b0, g, `FPQ_LOW_PSTAT, 16'h0000};
				default: fpq_step = {1'b1, 1'b1, a, `FPQ_CMD_RESET};
				endcase
			end
			`FPQ_OP_PROT, `FPQ_OP_UNPROT: begin
				case (step)
				3'h0, 3'h1: begin
					if (op == `FPQ_OP_PROT)
						fpq_step = {1'b0, 1'b1, g, `FPQ_LOW_PROT, `FPQ_CMD_PROTECT};
					else
						fpq_step = {1'b0, 1'b1, g, `FPQ_LOW_UNPROT, `FPQ_CMD_PROTECT};
				end
				default: fpq_step = {1'b1, 1'b0, g, `FPQ_LOW_PSTAT, 16'h0000};
				endcase
			end
			default: fpq_step = {1'b1, 1'b0, a, 16'h0000};
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg [4:0] st_q;
	reg [2:0] op_q;
	reg [2:0] step_q;
	reg die_q;
	reg temp_q;
	reg seq_elev_q;
	reg [22:0] addr_q;
	reg [15:0] wdata_q;
	reg [15:0] rdata_q;
	reg refused_q;
	reg [1:0] query_q;
	reg [`FPQ_CNT_W-1:0] cnt_q;
	reg cyc_start_q;
	reg [31:0] shadow_q [0:1];

	wire apb_wr;
	wire [2:0] apb_idx;
	wire cyc_done;
	wire [15:0] cyc_rdata;
	wire [40:0] cur;
	wire start_req;
	wire [2:0] req_op;
	wire req_die;
	wire req_prot_tgt;
	wire refuse;
	wire busy;
	wire [31:0] ctrl_word;
	wire [31:0] status_word;

	assign cur = fpq_step(op_q, step_q, addr_q, wdata_q);
	assign busy = (st_q != S_IDLE);
	assign req_op = I_PWDATA[`FPQ_CTRL_OP_HI:`FPQ_CTRL_OP_LO];
	assign req_die = I_PWDATA[`FPQ_CTRL_DIE];
	assign start_req = apb_wr && (apb_idx == 3'h0) && (req_op != `FPQ_OP_NONE);
	assign req_prot_tgt = shadow_q[req_die][fpq_grp(addr_q)];

	// refusals: low supply, unprotect before full protect, protected target,
	// autoselect entry from query mode, anything while busy
	assign refuse = busy
		|| I_SUPPLY_LOW
		|| ((req_op == `FPQ_OP_UNPROT) && (shadow_q[req_die] != `FPQ_ALL_PROT))
		|| ((req_op == `FPQ_OP_WRITE) && req_prot_tgt && !temp_q)
		|| ((req_op == `FPQ_OP_PSTAT) && (query_q[req_die] == 1'b1));

	assign ctrl_word = {23'h000000, temp_q, 3'h0, die_q, 1'b0, op_q};
	assign status_word = {27'h0000000, O_ELEV_EN, I_SUPPLY_LOW, query_q[die_q], refused_q, busy};
	// elevated level: software temporary unprotect or sequencer protect window
	assign O_ELEV_EN = temp_q | seq_elev_q;

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	fpq_apb u_apb (
		.i_clk(I_MCLK),
		.i_rst(I_SYS_RST),
		.i_psel(I_PSEL),
		.i_penable(I_PENABLE),
		.i_pwrite(I_PWRITE),
		.i_paddr(I_PADDR),
		.i_ctrl(ctrl_word),
		.i_addr({9'h000, addr_q}),
		.i_wdata({16'h0000, wdata_q}),
		.i_rdata({16'h0000, rdata_q}),
		.i_status(status_word),
		.i_prot0(shadow_q[0]),
		.i_prot1(shadow_q[1]),
		.o_prdata(O_PRDATA),
		.o_pready(O_PREADY),
		.o_pslverr(O_PSLVERR),
		.o_wr_en(apb_wr),
		.o_idx(apb_idx)
	);

	// ----------------------------------------------------------------
	// flash cycle engine; strobes idle high from reset onward
	// ----------------------------------------------------------------
	fpq_cyc u_cyc (
		.i_clk(I_MCLK),
		.i_rst(I_SYS_RST),
		.i_start(cyc_start_q),
		.i_write(cur[39]),
		.i_addr(cur[38:16]),
		.i_wdata(cur[15:0]),
		.i_die(die_q),
		.i_dq(I_FLASH_DQ),
		.o_addr(O_FLASH_ADDR),
		.o_dq(O_FLASH_DQ),
		.o_dq_oe(O_FLASH_DQ_OE),
		.o_die0_n(O_DIE0_SELECT_N),
		.o_die1_n(O_DIE1_SELECT_N),
		.o_we_n(O_WRITE_N),
		.o_oe_n(O_OUTPUT_EN_N),
		.o_done(cyc_done),
		.o_rdata(cyc_rdata)
	);

	// ----------------------------------------------------------------
	// operation sequencer
	// ----------------------------------------------------------------
	always @(posedge I_MCLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			st_q <= S_IDLE;
			op_q <= `FPQ_OP_NONE;
			step_q <= 3'h0;
			die_q <= 1'b0;
			temp_q <= 1'b0;
			seq_elev_q <= 1'b0;
			addr_q <= 23'h000000;
			wdata_q <= 16'h0000;
			rdata_q <= 16'h0000;
			refused_q <= 1'b0;
			query_q <= 2'b00;
			cnt_q <= {`FPQ_CNT_W{1'b0}};
			cyc_start_q <= 1'b0;
			shadow_q[0] <= `FPQ_NONE_PROT;
			shadow_q[1] <= `FPQ_NONE_PROT;
		end else begin
			cyc_start_q <= 1'b0;
			if (apb_wr && (apb_idx == 3'h1) && !busy)
				addr_q <= I_PWDATA[22:0];
			if (apb_wr && (apb_idx == 3'h2) && !busy)
				wdata_q <= I_PWDATA[15:0];
			if (apb_wr && (apb_idx == 3'h0))
				temp_q <= I_PWDATA[`FPQ_CTRL_TEMP];
			if (I_SUPPLY_LOW)
				query_q <= 2'b00;
			case (st_q)
			S_IDLE: begin
				if (start_req) begin
					refused_q <= refuse;
					if (!refuse) begin
						op_q <= req_op;
						die_q <= req_die;
						step_q <= 3'h0;
						if ((req_op == `FPQ_OP_PROT) || (req_op == `FPQ_OP_UNPROT)) begin
							seq_elev_q <= 1'b1;
							cnt_q <= ELEV_LOAD[`FPQ_CNT_W-1:0];
							st_q <= S_ELUP;
						end else begin
							st_q <= S_CYC;
						end
					end
				end
			end
			S_ELUP: begin
				if (cnt_q == {`FPQ_CNT_W{1'b0}})
					st_q <= S_CYC;
				else
					cnt_q <= cnt_q - 1'b1;
			end
			S_CYC: begin
				cyc_start_q <= 1'b1;
				st_q <= S_WAIT;
			end
			S_WAIT: begin
				if (cyc_done) begin
					if (!cur[39]) begin
						rdata_q <= cyc_rdata;
						if (op_q == `FPQ_OP_PSTAT || op_q == `FPQ_OP_PROT)
							shadow_q[die_q][fpq_grp(addr_q)] <=
								(cyc_rdata[7:0] == `FPQ_PROT_YES);
						if (op_q == `FPQ_OP_UNPROT && cyc_rdata[7:0] != `FPQ_PROT_YES)
							shadow_q[die_q] <= `FPQ_NONE_PROT;
					end
					if (op_q == `FPQ_OP_QUERY)
						query_q[die_q] <= 1'b1;
					if (op_q == `FPQ_OP_RESET)
						query_q[die_q] <= 1'b0;
					if (cur[40]) begin
						if (seq_elev_q) begin
							cnt_q <= ELEV_LOAD[`FPQ_CNT_W-1:0];
							st_q <= S_ELDN;
						end else begin
							st_q <= S_IDLE;
						end
					end else begin
						step_q <= step_q + 3'h1;
						st_q <= S_CYC;
					end
				end
			end
			S_ELDN: begin
				seq_elev_q <= 1'b0;
				if (cnt_q == {`FPQ_CNT_W{1'b0}})
					st_q <= S_IDLE;
				else
					cnt_q <= cnt_q - 1'b1;
			end
			default: st_q <= S_IDLE;
			endcase
		end
	end
endmodule // fpq_ctrl
`default_nettype wire

// ==== dv/fpq_ctrl_assertions.sv ====
// pin-level assertions for the flash protection and query controller
`timescale 1ns/1ps
`default_nettype none
module fpq_ctrl_assertions (
	input wire logic I_MCLK,
	input wire logic I_SYS_RST,
	input wire logic [15:0] O_FLASH_DQ,
	input wire logic O_FLASH_DQ_OE,
	input wire logic [22:0] O_FLASH_ADDR,
	input wire logic O_DIE0_SELECT_N,
	input wire logic O_DIE1_SELECT_N,
	input wire logic O_WRITE_N,
	input wire logic O_OUTPUT_EN_N,
	input wire logic O_ELEV_EN
);
	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (I_SYS_RST);
	wire sel = !O_DIE0_SELECT_N || !O_DIE1_SELECT_N;
	sequence s_we_pulse;
		!O_WRITE_N [*4] ##1 O_WRITE_N;
	endsequence
	sequence s_prot_cmd;
		!O_WRITE_N && O_FLASH_DQ == 16'h0060;
	endsequence
	a_we_oe_excl: assert property (!(!O_WRITE_N && !O_OUTPUT_EN_N))
		else $error("write strobe and output enable low together");
	a_one_die: assert property (!(!O_DIE0_SELECT_N && !O_DIE1_SELECT_N))
		else $error("both dies selected");
	a_we_drive: assert property (!O_WRITE_N |-> sel && O_FLASH_DQ_OE)
		else $error("write strobe without select or data drive");
	a_we_width: assert property ($fell(O_WRITE_N) |-> s_we_pulse)
		else $error("write strobe pulse width wrong");
	a_we_stable: assert property (!O_WRITE_N |-> $stable(O_FLASH_ADDR) && $stable(O_FLASH_DQ))
		else $error("address or data moved under write strobe");
	a_sel_hold: assert property ($rose(O_WRITE_N) |-> sel)
		else $error("select rose before write strobe");
	a_prot_elev: assert property (s_prot_cmd |-> O_ELEV_EN)
		else $error("protect command without elevated level");
	a_prot_group: assert property (s_prot_cmd |-> O_FLASH_ADDR[17:0] inside {18'h0, 18'h40})
		else $error("protect command off group address");
	a_query_addr: assert property ($fell(O_WRITE_N) && O_FLASH_DQ == 16'h0098 |-> O_FLASH_ADDR == 23'h55)
		else $error("query command at wrong address");
	a_read_hiz: assert property (!O_OUTPUT_EN_N |-> sel && !O_FLASH_DQ_OE)
		else $error("read with bus driven or no select");
endmodule // fpq_ctrl_assertions
bind fpq_ctrl fpq_ctrl_assertions u_chk (.I_MCLK(I_MCLK), .I_SYS_RST(I_SYS_RST),
	.O_FLASH_DQ(O_FLASH_DQ), .O_FLASH_DQ_OE(O_FLASH_DQ_OE), .O_FLASH_ADDR(O_FLASH_ADDR),
	.O_DIE0_SELECT_N(O_DIE0_SELECT_N), .O_DIE1_SELECT_N(O_DIE1_SELECT_N),
	.O_WRITE_N(O_WRITE_N), .O_OUTPUT_EN_N(O_OUTPUT_EN_N), .O_ELEV_EN(O_ELEV_EN));
`default_nettype wire

// ==== dv/fpq_flash_mdl.sv ====
// behavioural two-die flash: group protection, query table, identification
`timescale 1ns/1ps
`default_nettype none
module fpq_flash_mdl (
	input wire logic [22:0] i_addr,
	input wire logic [15:0] i_dq,
	input wire logic i_sel0_n,
	input wire logic i_sel1_n,
	input wire logic i_we_n,
	input wire logic i_oe_n,
	input wire logic i_elev,
	input wire logic i_supply_low,
	output logic [15:0] o_dq,
	output logic [31:0] o_wr,
	output logic o_err
);
	localparam logic [183:0] CFI = 184'h5152_5902_0040_0000_0000_0030_3600_0004_000A_0005_0004_00;
	logic [1:0][31:0] prot_q;
	logic [1:0] qry_q, id_q, vfy_q, upv_q;
	logic [22:0] adr_q;
	logic arm_q;
	wire d = i_sel0_n;
	wire sel = !i_sel0_n || !i_sel1_n;
	initial begin
		prot_q = '0;
		{qry_q, id_q, vfy_q, upv_q} = '0;
		o_wr = 0;
		o_err = 0;
		o_dq = 16'h0;
		arm_q = 1'b0;
	end
	// commands count only once the strobes have been seen idle after power-up
	always @(i_we_n or sel) if (i_we_n === 1'b1 && sel === 1'b0) arm_q = 1'b1;
	function automatic logic [15:0] rdv(input logic [22:0] a, input logic dd);
		if (qry_q[dd])
			return (a[7:0] inside {[8'h10:8'h26]}) ? {8'h00, CFI[8 * (8'h26 - a[7:0]) +: 8]} : 16'h0;
		if (id_q[dd] || vfy_q[dd])
			return {15'h0, prot_q[dd][a[22:18]]};
		return a[15:0] ^ 16'h5A5A;
	endfunction
	always @(negedge i_oe_n) begin
		if (sel) begin
			o_dq = rdv(i_addr, d);
			vfy_q[d] = 1'b0;
		end
	end
	// a released bus shows the inverse of the last value
	always @(posedge i_oe_n) o_dq = ~o_dq;
	always @(negedge i_we_n) adr_q = i_addr;
	always @(posedge i_supply_low) {qry_q, id_q} = '0;
	always @(posedge i_we_n) begin
		if (arm_q && sel && i_oe_n && !i_supply_low) begin
			case (i_dq)
				16'h0098: qry_q[d] = qry_q[d] | (adr_q[7:0] == 8'h55);
				16'h00F0: {qry_q[d], id_q[d]} = {1'b0, id_q[d] & qry_q[d]};
				16'h0090: id_q[d] = 1'b1;
				16'h00AA, 16'h0055: ;
				16'h0060: if (i_elev) begin
					vfy_q[d] = 1'b1;
					if (!adr_q[6])
						prot_q[d][adr_q[22:18]] = 1'b1;
					else if (!upv_q[d])
						o_err = o_err | (prot_q[d] != 32'hFFFFFFFF);
					else
						prot_q[d] = 32'h0;
					if (adr_q[6])
						upv_q[d] = !upv_q[d];
				end
				default: o_wr = o_wr + (!prot_q[d][adr_q[22:18]] || i_elev);
			endcase
		end
	end
endmodule // fpq_flash_mdl
`default_nettype wire

// ==== dv/tb_top.sv ====
// self-checking bench for the flash protection and query controller
`timescale 1ns/1ps
`default_nettype none
`include "fpq_regs.vh"
module tb_top;
	localparam logic [183:0] CFI = 184'h5152_5902_0040_0000_0000_0030_3600_0004_000A_0005_0004_00;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slo = 1'b0, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rd;
	logic [15:0] rnd = 16'h0011, wd;
	logic [22:0] fa;
	logic [4:0] g;
	int fail_count = 0, tests_run = 0, i, w0;
	wire [31:0] prdata, wr_n;
	wire [15:0] fdq, mdl_dq;
	wire [22:0] fad;
	wire pready, pslverr, dq_oe, s0_n, s1_n, we_n, oe_n, elev, merr;
	wire [15:0] bus = dq_oe ? fdq : mdl_dq;
	fpq_ctrl DUT (.I_MCLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .I_SUPPLY_LOW(slo), .I_FLASH_DQ(bus),
		.O_FLASH_DQ(fdq), .O_FLASH_DQ_OE(dq_oe), .O_FLASH_ADDR(fad), .O_DIE0_SELECT_N(s0_n),
		.O_DIE1_SELECT_N(s1_n), .O_WRITE_N(we_n), .O_OUTPUT_EN_N(oe_n), .O_ELEV_EN(elev));
	fpq_flash_mdl u_flash (.i_addr(fad), .i_dq(bus), .i_sel0_n(s0_n), .i_sel1_n(s1_n),
		.i_we_n(we_n), .i_oe_n(oe_n), .i_elev(elev), .i_supply_low(slo), .o_dq(mdl_dq),
		.o_wr(wr_n), .o_err(merr));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [15:0] arr(input logic [22:0] a);
		return a[15:0] ^ 16'h5A5A;
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			$display("wrong value %s expected %h seen %h", n, e, s);
			fail_count++;
		end
	endtask
	task automatic ended(input string n);
		$display("test %s finished", n);
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic op(input logic [2:0] o, input logic dd, input logic t,
		input logic [22:0] a, input logic [15:0] d);
		int k;
		apb(1, `FPQ_OFF_ADDR, {9'h0, a});
		apb(1, `FPQ_OFF_WDATA, {16'h0, d});
		apb(1, `FPQ_OFF_CTRL, {23'h0, t, 3'h0, dd, 1'b0, o});
		k = 0;
		do begin
			apb(0, `FPQ_OFF_STATUS, 0);
			k++;
		end while (rd[`FPQ_ST_BUSY] !== 1'b0 && k < 400);
		chk("busy", 0, rd[`FPQ_ST_BUSY]);
	endtask
	task automatic rdw(input logic dd, input logic [22:0] a);
		op(`FPQ_OP_READ, dd, 0, a, 0);
		apb(0, `FPQ_OFF_RDATA, 0);
	endtask
	initial forever #5 clk = ~clk;
	initial begin
		#1000000;
		fail_count++;
		complete_run();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		apb(0, `FPQ_OFF_PROT0, 0);
		chk("prot0", 0, rd);
		apb(0, `FPQ_OFF_STATUS, 0);
		chk("status", 0, rd);
		apb(0, 8'h40, 0);
		chk("slverr", 1, err);
		ended("reset");
		op(`FPQ_OP_QUERY, 0, 0, 0, 0);
		chk("query mode", 1, rd[`FPQ_ST_QUERY]);
		for (i = 16; i < 39; i++) begin
			rdw(0, i[22:0]);
			chk("cfi", {8'h00, CFI[8 * (38 - i) +: 8]}, rd[15:0]);
		end
		repeat (4) begin
			rnd = lfsr(rnd);
			rdw(0, 23'h50 + rnd[4:0]);
			chk("cfi gap", 0, rd[15:0]);
		end
		fa = {rnd[7:0], rnd[14:0]};
		rdw(1, fa);
		chk("die1 array", arr(fa), rd[15:0]);
		op(`FPQ_OP_RESET, 0, 0, 0, 0);
		chk("query off", 0, rd[`FPQ_ST_QUERY]);
		rdw(0, fa);
		chk("die0 array", arr(fa), rd[15:0]);
		ended("query");
		rnd = lfsr(rnd);
		g = rnd[4:0];
		fa = {g, rnd[15:0], 2'b00};
		op(`FPQ_OP_PSTAT, 0, 0, fa, 0);
		apb(0, `FPQ_OFF_RDATA, 0);
		chk("pstat clear", 0, rd[7:0]);
		op(`FPQ_OP_UNPROT, 0, 0, fa, 0);
		chk("unprot refused", 1, rd[`FPQ_ST_REFUSED]);
		op(`FPQ_OP_PROT, 0, 0, fa, 0);
		apb(0, `FPQ_OFF_PROT0, 0);
		chk("prot0 group", 32'h1 << g, rd);
		op(`FPQ_OP_PSTAT, 0, 0, fa, 0);
		apb(0, `FPQ_OFF_RDATA, 0);
		chk("pstat set", 8'h01, rd[7:0]);
		wd = rnd | 16'h8000;
		w0 = wr_n;
		op(`FPQ_OP_WRITE, 0, 0, fa, wd);
		chk("write refused", 1, rd[`FPQ_ST_REFUSED]);
		chk("no cycle", w0, wr_n);
		// the temp bit counts for refusals from the next ctrl write on
		op(`FPQ_OP_NONE, 0, 1, fa, wd);
		chk("elev raised", 1, rd[`FPQ_ST_ELEV]);
		op(`FPQ_OP_WRITE, 0, 1, fa, wd);
		chk("temp accepted", 0, rd[`FPQ_ST_REFUSED]);
		chk("temp cycle", w0 + 1, wr_n);
		chk("elev on", 1, rd[`FPQ_ST_ELEV]);
		op(`FPQ_OP_NONE, 0, 0, fa, wd);
		op(`FPQ_OP_WRITE, 0, 0, fa, wd);
		chk("reprotected", 1, rd[`FPQ_ST_REFUSED]);
		chk("elev off", 0, rd[`FPQ_ST_ELEV]);
		slo <= 1'b1;
		fa[22:18] = g + 5'h1;
		op(`FPQ_OP_WRITE, 0, 0, fa, wd);
		chk("low refused", 1, rd[`FPQ_ST_REFUSED]);
		chk("low flag", 1, rd[`FPQ_ST_SUPPLY_LOW]);
		chk("low cycle", w0 + 1, wr_n);
		slo <= 1'b0;
		ended("protect");
		for (i = 0; i < 32; i++)
			op(`FPQ_OP_PROT, 1, 0, {i[4:0], 18'h0}, 0);
		apb(0, `FPQ_OFF_PROT1, 0);
		chk("prot1 all", 32'hFFFFFFFF, rd);
		op(`FPQ_OP_UNPROT, 1, 0, 0, 0);
		apb(0, `FPQ_OFF_PROT1, 0);
		chk("prot1 none", 0, rd);
		apb(0, `FPQ_OFF_PROT0, 0);
		chk("prot0 kept", 32'h1 << g, rd);
		chk("unprot order", 0, merr);
		ended("unprotect");
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
